// ===== verilog/stc_sleep_counter.v
// Purpose: Sleep tick counter with control register and wake-source status on Wishbone.
// Assumes: Classic Wishbone, 32-bit data, byte address = 4 * register index.
// Notes:   Ack comes one cycle after the request; shadow registers are simple stand-ins.
//
// Summary of operation
// - Once running the counter keeps counting and wraps in run and every stop mode.
// - With the page bit set, the counter high byte reads at 0x1808 and low byte at 0x1809.
// - Writing 1 to control bit 7 zeroes the counter; writing 0 does nothing.
// - The counter advances on both oscillator edges, so 1 may show just after a clear.
// - Control bit 5 set to 0 freezes the counter and set to 1 lets it count.
// - With the page bit clear, 0x1808 and 0x1809 reach the shadowed registers again.
// - The clear and run bits act only while the page bit is 1.
// - The counter clock runs whenever powered, independent of processor activity.
// - The wake-source register records the last wake cause and clears on stop entry.
// - Bus writes to the wake-source register are ignored.
// - Bit 5 marks a keypad wake and bit 4 an external interrupt pin wake.
// - Bits 3..0 mark temperature restart, periodic wakeup, LF receiver and RF wakes.
`default_nettype none
`include "stc_defs.vh"

module stc_sleep_counter (
  input  wire        core_clk,
  input  wire        reset,
  input  wire        lfo_clk,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [15:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output wire        wb_ack_o,
  input  wire        stop_entry,
  input  wire        wake_event,
  input  wire [5:0]  wake_cause,
  output wire        counter_running
);

  localparam [0:0] BUS_IDLE   = 1'b0;
  localparam [0:0] BUS_ANSWER = 1'b1;

  reg         bus_state;
  reg         next_bus_state;
  reg         page_sel;
  reg         next_page_sel;
  reg         run_bit;
  reg         next_run_bit;
  reg         clear_toggle;
  reg         next_clear_toggle;
  reg  [7:0]  shadow_a;
  reg  [7:0]  next_shadow_a;
  reg  [7:0]  shadow_b;
  reg  [7:0]  next_shadow_b;
  reg  [7:0]  wake_status;
  reg  [7:0]  next_wake_status;
  reg  [15:0] cnt_s1;
  reg  [15:0] cnt_s2;
  reg  [15:0] cnt_s3;
  reg  [15:0] cnt_bus;
  reg  [15:0] next_cnt_bus;
  reg  [7:0]  next_rdata;
  reg  [31:0] next_dat_o;
  reg  [2:0]  clr_sync;
  reg  [2:0]  run_sync;
  reg         clr_level;
  reg         next_clr_level;
  reg         run_level;
  reg         next_run_level;
  wire [15:0] lfo_count;
  wire [13:0] reg_idx;
  wire        hit_high;
  wire        hit_low;
  wire        hit_ctrl;
  wire        hit_wake;
  wire        ack;
  wire        req;
  wire        commit;
  wire        wr_lane0;
  wire        wr_ctrl;
  wire        wr_shadow_a;
  wire        wr_shadow_b;

  // Compares a register index with the low 14 bits of a 16-bit register number.
  function [0:0] idx_is;
    input [13:0] idx;
    input [15:0] target;
    begin
      idx_is = (idx == target[13:0]);
    end
  endfunction

  // Control register as read back: only the run bit is readable.
  function [7:0] ctrl_image;
    input run;
    begin
      ctrl_image = `STC_RST_BYTE;
      ctrl_image[`STC_BIT_RUN] = run;
    end
  endfunction

  // Counter byte while the page bit is set, otherwise the shadowed register.
  function [7:0] paged_byte;
    input       page;
    input [7:0] count_byte;
    input [7:0] shadow_byte;
    begin
      if (page) begin
        paged_byte = count_byte;
      end else begin
        paged_byte = shadow_byte;
      end
    end
  endfunction

  // Places each wake cause on its flag bit; the top two bits always read 0.
  function [7:0] wake_image;
    input [5:0] cause;
    begin
      wake_image = `STC_RST_BYTE;
      wake_image[`STC_BIT_KEYPAD]   = cause[5];
      wake_image[`STC_BIT_EXT_IRQ]  = cause[4];
      wake_image[`STC_BIT_TEMP]     = cause[3];
      wake_image[`STC_BIT_PERIODIC] = cause[2];
      wake_image[`STC_BIT_LF]       = cause[1];
      wake_image[`STC_BIT_RF]       = cause[0];
      wake_image = wake_image & `STC_WAKE_MASK;
    end
  endfunction

  assign reg_idx     = wb_adr_i[15:2];
  assign hit_high    = idx_is(reg_idx, `STC_IDX_VALUE_HIGH);
  assign hit_low     = idx_is(reg_idx, `STC_IDX_VALUE_LOW);
  assign hit_ctrl    = idx_is(reg_idx, `STC_IDX_CONTROL);
  assign hit_wake    = idx_is(reg_idx, `STC_IDX_WAKE_SOURCE);
  assign ack         = (bus_state == BUS_ANSWER);
  assign req         = wb_cyc_i & wb_stb_i & ~ack;
  // A write takes effect on the edge at which the master samples ack.
  assign commit      = wb_cyc_i & wb_stb_i & ack;
  assign wr_lane0    = commit & wb_we_i & wb_sel_i[0];
  assign wr_ctrl     = wr_lane0 & hit_ctrl;
  assign wr_shadow_a = wr_lane0 & hit_high & ~page_sel;
  assign wr_shadow_b = wr_lane0 & hit_low & ~page_sel;
  assign wb_ack_o    = ack;
  assign counter_running = run_bit;

  stc_tick_counter u_tick (
    .lfo_clk      (lfo_clk),
    .reset        (reset),
    .run          (run_level),
    .clear_toggle (clr_level),
    .count        (lfo_count)
  );

  // Oscillator-side capture of the bus-domain control levels; a change counts only
  // once stages two and three agree, so a level caught mid-change is never used.
  always @(posedge lfo_clk) begin
    if (reset) begin
      clr_sync <= 3'b000;
      run_sync <= 3'b000;
    end else begin
      clr_sync <= {clr_sync[1:0], clear_toggle};
      run_sync <= {run_sync[1:0], run_bit};
    end
  end

  always @* begin
    next_run_level = run_level;
    next_clr_level = clr_level;
    if (run_sync[2] == run_sync[1]) begin
      next_run_level = run_sync[2];
    end
    if (clr_sync[2] == clr_sync[1]) begin
      next_clr_level = clr_sync[2];
    end
  end

  always @(posedge lfo_clk) begin
    if (reset) begin
      run_level <= 1'b0;
      clr_level <= 1'b0;
    end else begin
      run_level <= next_run_level;
      clr_level <= next_clr_level;
    end
  end

  always @* begin
    next_bus_state = bus_state;
    case (bus_state)
      BUS_IDLE: begin
        if (req) begin
          next_bus_state = BUS_ANSWER;
        end
      end
      BUS_ANSWER: begin
        next_bus_state = BUS_IDLE;
      end
      default: begin
        next_bus_state = BUS_IDLE;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (reset) begin
      bus_state <= BUS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  // Three-stage capture; a value is taken only when stages two and three agree.
  always @(posedge core_clk) begin
    if (reset) begin
      cnt_s1 <= `STC_RST_COUNT;
      cnt_s2 <= `STC_RST_COUNT;
      cnt_s3 <= `STC_RST_COUNT;
    end else begin
      cnt_s1 <= lfo_count;
      cnt_s2 <= cnt_s1;
      cnt_s3 <= cnt_s2;
    end
  end

  always @* begin
    next_cnt_bus = cnt_bus;
    if (cnt_s2 == cnt_s3) begin
      next_cnt_bus = cnt_s3;
    end
  end

  always @(posedge core_clk) begin
    if (reset) begin
      cnt_bus <= `STC_RST_COUNT;
    end else begin
      cnt_bus <= next_cnt_bus;
    end
  end

  // The page bit always takes the write; run and clear act only if it was already set.
  always @* begin
    next_page_sel     = page_sel;
    next_run_bit      = run_bit;
    next_clear_toggle = clear_toggle;
    if (wr_ctrl) begin
      next_page_sel = wb_dat_i[`STC_BIT_PAGE];
      if (page_sel) begin
        next_run_bit = wb_dat_i[`STC_BIT_RUN];
        if (wb_dat_i[`STC_BIT_CLEAR]) begin
          next_clear_toggle = ~clear_toggle;
        end
      end
    end
  end

  always @(posedge core_clk) begin
    if (reset) begin
      page_sel     <= 1'b0;
      run_bit      <= 1'b0;
      clear_toggle <= 1'b0;
    end else begin
      page_sel     <= next_page_sel;
      run_bit      <= next_run_bit;
      clear_toggle <= next_clear_toggle;
    end
  end

  // Counter bytes and wake status take no writes.
  always @* begin
    next_shadow_a = shadow_a;
    next_shadow_b = shadow_b;
    if (wr_shadow_a) begin
      next_shadow_a = wb_dat_i[7:0];
    end
    if (wr_shadow_b) begin
      next_shadow_b = wb_dat_i[7:0];
    end
  end

  always @(posedge core_clk) begin
    if (reset) begin
      shadow_a <= `STC_RST_SHADOW_A;
      shadow_b <= `STC_RST_SHADOW_B;
    end else begin
      shadow_a <= next_shadow_a;
      shadow_b <= next_shadow_b;
    end
  end

  // Wake status: cleared on stop entry, loaded by the wake event; the event wins.
  always @* begin
    next_wake_status = wake_status;
    if (wake_event) begin
      next_wake_status = wake_image(wake_cause);
    end else if (stop_entry) begin
      next_wake_status = `STC_RST_BYTE;
    end
  end

  always @(posedge core_clk) begin
    if (reset) begin
      wake_status <= `STC_RST_BYTE;
    end else begin
      wake_status <= next_wake_status;
    end
  end

  always @* begin
    next_rdata = `STC_RST_BYTE;
    if (hit_high) begin
      next_rdata = paged_byte(page_sel, cnt_bus[15:8], shadow_a);
    end else if (hit_low) begin
      next_rdata = paged_byte(page_sel, cnt_bus[7:0], shadow_b);
    end else if (hit_ctrl) begin
      next_rdata = ctrl_image(run_bit);
    end else if (hit_wake) begin
      next_rdata = wake_status;
    end
  end

  // Read data is taken when the request is accepted and stands until the next one.
  always @* begin
    next_dat_o = wb_dat_o;
    if (req) begin
      next_dat_o = {24'h000000, next_rdata};
    end
  end

  always @(posedge core_clk) begin
    if (reset) begin
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_dat_o <= next_dat_o;
    end
  end

endmodule
`default_nettype wire

// ===== verilog/stc_defs.vh
// Purpose: Register map, field positions and reset values of the sleep tick counter block.
// Assumes: Included by the design files under verilog/.
// Notes:   Offsets are not multiples of four, so byte address is four times the index.
`ifndef STC_DEFS_VH
`define STC_DEFS_VH

`define STC_IDX_VALUE_HIGH   16'h1808
`define STC_IDX_VALUE_LOW    16'h1809
`define STC_IDX_CONTROL      16'h180b
`define STC_IDX_WAKE_SOURCE  16'h180d
`define STC_IDX_SHADOW_A     16'h1808
`define STC_IDX_SHADOW_B     16'h1809

`define STC_BIT_CLEAR        7
`define STC_BIT_RUN          5
`define STC_BIT_PAGE         0

`define STC_BIT_KEYPAD       5
`define STC_BIT_EXT_IRQ      4
`define STC_BIT_TEMP         3
`define STC_BIT_PERIODIC     2
`define STC_BIT_LF           1
`define STC_BIT_RF           0

`define STC_RST_BYTE         8'h00
`define STC_RST_COUNT        16'h0000
`define STC_RST_SHADOW_A     8'h00
`define STC_RST_SHADOW_B     8'h00
`define STC_WAKE_MASK        8'h3f

`endif

// ===== verilog/stc_tick_counter.v
// Purpose: 16-bit sleep tick counter in the low-frequency oscillator domain.
// Assumes: lfo_clk runs whenever power is present; control levels come in already settled.
// Notes:   Counts on both edges of lfo_clk through two half-rate registers.
`default_nettype none
`include "stc_defs.vh"

module stc_tick_counter (
  input  wire        lfo_clk,
  input  wire        reset,
  input  wire        run,
  input  wire        clear_toggle,
  output wire [15:0] count
);

  reg  [15:0] rise_count;
  reg  [15:0] fall_count;
  reg         rise_clr_seen;
  wire [16:0] sum;
  wire        clr_req;

  // The count is the sum of both halves, so each oscillator edge adds one.
  assign sum     = {1'b0, rise_count} + {1'b0, fall_count};
  assign count   = sum[15:0];
  assign clr_req = clear_toggle ^ rise_clr_seen;

  // Increment and wrap in every power mode while running.
  always @(posedge lfo_clk) begin
    if (reset) begin
      rise_count    <= `STC_RST_COUNT;
      rise_clr_seen <= 1'b0;
    end else if (clr_req) begin
      // Cancelling the falling half zeroes the sum at once, so no stale half shows.
      rise_count    <= `STC_RST_COUNT - fall_count;
      rise_clr_seen <= clear_toggle;
    end else if (run) begin
      rise_count <= rise_count + 16'h0001;
    end
  end

  always @(negedge lfo_clk) begin
    if (reset) begin
      fall_count <= `STC_RST_COUNT;
    end else if (run) begin
      fall_count <= fall_count + 16'h0001;
    end
  end

endmodule
`default_nettype wire

// ===== tb/stc_sleep_counter_chk.sv
// Purpose: Port-level assertions for the sleep tick counter block.
// Assumes: Bound to stc_sleep_counter; one bus clock domain.
// Notes:   Byte addresses are four times the register index.
`default_nettype none
module stc_sleep_counter_chk (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        counter_running
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic rd = wb_ack_o && !wb_we_i;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_hi_zero; rd |-> wb_dat_o[31:8] == 24'h0; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
  property p_run_write;
    $changed(counter_running) |-> $past(wb_stb_i && wb_we_i && wb_adr_i == 16'h602c);
  endproperty
  a_run_write: assert property (p_run_write) else $error("run changed unasked");
  property p_ctrl_read;
    rd && wb_adr_i == 16'h602c |-> wb_dat_o[7:0] == {2'b00, counter_running, 5'h00};
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control readback");
  property p_wake_top; rd && wb_adr_i == 16'h6034 |-> wb_dat_o[7:6] == 2'b00; endproperty
  a_wake_top: assert property (p_wake_top) else $error("wake top bits set");
  property p_rst;
    disable iff (1'b0) reset |=> !wb_ack_o && !counter_running && wb_dat_o == 32'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  c_run: cover property ($rose(counter_running));
  c_wake: cover property (rd && wb_adr_i == 16'h6034 && wb_dat_o[5:0] != 6'h0);
  c_ctrl: cover property (wb_ack_o && wb_we_i && wb_adr_i == 16'h602c);
endmodule
`default_nettype wire

// ===== tb/stc_sleep_counter_bench.sv
// Purpose: Self-checking bench for the sleep tick counter block.
// Assumes: Classic Wishbone with ack one cycle after the request.
// Notes:   The oscillator runs far faster than real so the run stays short.
`default_nettype none
module stc_sleep_counter_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk, reset, lfo_clk, wb_cyc_i, wb_stb_i, wb_we_i, stop_entry, wake_event;
  logic [15:0] wb_adr_i, c1, c2;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        wb_ack_o, counter_running;
  logic [5:0]  wake_cause;
  logic [7:0]  q, h;
  int          miscompares, check_count, cycles;
  stc_sleep_counter u_stc_sleep_counter (.*);
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  // Early fast edges let the oscillator-side halves see reset.
  initial begin
    lfo_clk = 0;
    repeat (4) #10 lfo_clk = ~lfo_clk;
    forever #500 lfo_clk = ~lfo_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic conclude;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rdcnt(output logic [15:0] c);
    bus(0, 16'h6020, 8'h00);
    h = q;
    bus(0, 16'h6024, 8'h00);
    c = {h, q};
  endtask
  task automatic wake(input logic [5:0] c);
    @(posedge core_clk);
    wake_cause <= c;
    wake_event <= 1'b1;
    @(posedge core_clk);
    wake_event <= 1'b0;
    bus(0, 16'h6034, 8'h00);
  endtask
  initial begin
    reset = 1;
    {wb_cyc_i, wb_stb_i, wb_we_i, stop_entry, wake_event} = '0;
    {wb_adr_i, wb_dat_i, wake_cause} = '0;
    wb_sel_i = 4'hf;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    bus(0, 16'h6034, 8'h00);
    chk("wake reset", q, 8'h00);
    bus(1, 16'h6020, 8'h5a);
    bus(1, 16'h602c, 8'h20);
    @(posedge core_clk);
    chk("run off page", {7'h0, counter_running}, 8'h00);
    bus(1, 16'h602c, 8'h01);
    bus(1, 16'h602c, 8'h21);
    @(posedge core_clk);
    chk("run set", {7'h0, counter_running}, 8'h01);
    repeat (700) @(posedge core_clk);
    rdcnt(c1);
    repeat (500) @(posedge core_clk);
    rdcnt(c2);
    chk("step", (c2 - c1 >= 16'd9 && c2 - c1 <= 16'd11) ? 8'h1 : 8'h0, 8'h1);
    bus(1, 16'h602c, 8'h01);
    repeat (700) @(posedge core_clk);
    rdcnt(c1);
    repeat (500) @(posedge core_clk);
    rdcnt(c2);
    chk("halted", c2[7:0], c1[7:0]);
    bus(1, 16'h602c, 8'h81);
    repeat (700) @(posedge core_clk);
    bus(1, 16'h6020, 8'hff);
    bus(1, 16'h6024, 8'hff);
    rdcnt(c1);
    chk("cleared", c1[7:0] | c1[15:8], 8'h00);
    bus(1, 16'h602c, 8'h21);
    bus(1, 16'h602c, 8'h20);
    bus(0, 16'h6020, 8'h00);
    chk("shadow back", q, 8'h5a);
    @(posedge core_clk);
    chk("run kept", {7'h0, counter_running}, 8'h01);
    for (int i = 0; i < 6; i++) begin
      wake(6'h1 << i);
      chk("wake flag", q, 8'h1 << i);
    end
    wake(6'h3f);
    bus(1, 16'h6034, {q[7:6], 6'h00});
    bus(0, 16'h6034, 8'h00);
    chk("wake kept", q, 8'h3f);
    @(posedge core_clk);
    stop_entry <= 1'b1;
    @(posedge core_clk);
    stop_entry <= 1'b0;
    bus(0, 16'h6034, 8'h00);
    chk("stop clears", q, 8'h00);
    conclude();
  end
endmodule
bind stc_sleep_counter stc_sleep_counter_chk u_stc_sleep_counter_chk (.*);
`default_nettype wire
